// file: isp_boot_security_control.sv
// programming control, boot source selection and security word handling
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

// What this block does
// - soft reset when bits 7,1,0 written high
// - bit 7 reads 1 in loader boot mode
// - bit 4 enables auxiliary RAM
// - location select picks loader and target banks
// - programming mode entered after idle and wake
// - programming disabled refuses every flash operation, reads included
// - default boot from application flash
// - straps low select loader boot at reset
// - loader boot executes from loader flash
// - security word blocked in programming mode
// - security bits only return through erase-all or hardware reset
// - security word at loader address FFFF
// - lock low denies flash reads and settings access
// - inhibit low keeps external code reads external
// - internal code reads always reach everything
// - encryption bit encodes port 0 data
// - oscillator bit low halves amplifier gain
// - register writable only after 87 then 59
module isp_boot_security_control
   import isp_boot_pkg::*;
#(
   parameter logic [7:0] P0_KEY = 8'h5A // arbitrary encoding key
)
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // boot straps
   input wire logic strap_p27_in,
   input wire logic strap_p26_in,
   input wire logic strap_p43_in,
   // cpu power state
   input wire logic cpu_idle_in,
   input wire logic wake_irq_in,
   // in-system flash operation requests
   input wire logic fl_req_in,
   input wire logic [1:0] fl_cmd_in,
   input wire logic [15:0] fl_addr_in,
   output logic fl_grant_out,
   output logic fl_refused_out,
   output logic fl_target_loader_out,
   // external programmer access to the security word
   input wire logic pg_sec_wr_in,
   input wire logic [7:0] pg_sec_data_in,
   input wire logic pg_erase_all_in,
   output logic pg_refused_out,
   // code-space reads
   input wire logic cr_req_in,
   input wire logic cr_from_internal_in,
   input wire logic cr_to_internal_in,
   output logic cr_internal_out,
   output logic cr_external_out,
   // port 0 data path
   input wire logic [7:0] p0_data_in,
   output logic [7:0] p0_data_out,
   // controls to the rest of the chip
   output logic soft_reset_out,
   output logic aux_ram_enable_out,
   output logic isp_active_out,
   output logic fetch_loader_out,
   output logic osc_half_gain_out,
   output logic encrypt_active_out
);
   logic [7:0] pbc;
   logic loader_boot_mode;
   logic strap_pending;
   logic soft_reset_req;
   logic [7:0] sec_word;
   isp_state_type isp_state;
   logic write_open;
   logic pbc_wr;
   logic unlock_wr;
   logic soft_hit;
   logic isp_on;
   logic locked;
   logic fl_sec_hit;
   logic fl_ok;

   // true when an access hits the security word location
   function automatic logic hits_sec_word(input logic loader_bank, input logic [15:0] addr);
      hits_sec_word = loader_bank && (addr == SEC_WORD_ADDR);
   endfunction

   assign unlock_wr = reg_wr_in && (reg_addr_in == UNLOCK_ADDR);
   assign pbc_wr = reg_wr_in && (reg_addr_in == PBC_ADDR) && write_open;
   assign soft_hit = pbc_wr && reg_wdata_in[PBC_SOFT_RESET_BIT] &&
                     reg_wdata_in[PBC_LOC_SEL_BIT] && reg_wdata_in[PBC_PROG_EN_BIT];
   assign isp_on = (isp_state == ISP_ON);
   assign locked = !sec_word[SEC_LOCK_BIT];
   assign fl_sec_hit = hits_sec_word(!pbc[PBC_LOC_SEL_BIT], fl_addr_in);

   write_unlock_seq u_unlock (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .clear_in(soft_reset_req),
      .key_wr_in(unlock_wr),
      .key_in(reg_wdata_in),
      .open_out(write_open)
   );

   // soft reset request, applied one cycle later to the control register, straps, programming mode and unlock
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         soft_reset_req <= 1'b0;
      end else begin
         soft_reset_req <= soft_hit;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         soft_reset_out <= 1'b0;
      end else begin
         soft_reset_out <= soft_hit;
      end
   end

   // programming control register; bits 7, 6, 5, 3 and 2 are kept at zero
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pbc <= PBC_RESET;
      end else if (soft_reset_req) begin
         pbc <= PBC_RESET;
      end else if (pbc_wr) begin
         pbc <= reg_wdata_in & PBC_WRITABLE;
      end
   end

   // straps are caught on the first edge after any reset
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_pending <= 1'b1;
      end else if (soft_reset_req) begin
         strap_pending <= 1'b1;
      end else begin
         strap_pending <= 1'b0;
      end
   end

   // board must hold straps at safe levels while this samples them
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         loader_boot_mode <= 1'b0;
      end else if (soft_reset_req) begin
         loader_boot_mode <= 1'b0;
      end else if (strap_pending) begin
         loader_boot_mode <= (!strap_p27_in && !strap_p26_in) || !strap_p43_in;
      end
   end

   // programming mode arms on idle entry and starts on the waking interrupt
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         isp_state <= ISP_OFF;
      end else if (soft_reset_req || !pbc[PBC_PROG_EN_BIT]) begin
         isp_state <= ISP_OFF;
      end else begin
         case (isp_state)
            ISP_OFF: begin
               if (cpu_idle_in) begin
                  isp_state <= ISP_ARMED;
               end
            end
            ISP_ARMED: begin
               if (wake_irq_in) begin
                  isp_state <= ISP_ON;
               end
            end
            default: begin
               isp_state <= ISP_ON;
            end
         endcase
      end
   end

   // flash operations run only while idle in programming mode
   always_comb begin
      fl_ok = isp_on && cpu_idle_in && pbc[PBC_PROG_EN_BIT];
      if (fl_sec_hit) begin
         fl_ok = 1'b0;
      end
      if (locked && (fl_cmd_in == FL_CMD_READ)) begin
         fl_ok = 1'b0;
      end
      if (fl_cmd_in != FL_CMD_READ && fl_cmd_in != FL_CMD_PROGRAM &&
          fl_cmd_in != FL_CMD_ERASE) begin
         fl_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fl_grant_out <= 1'b0;
      end else begin
         fl_grant_out <= fl_req_in && fl_ok;
      end
   end

   // refusal pulse, exactly one of grant or refusal answers each request
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fl_refused_out <= 1'b0;
      end else begin
         fl_refused_out <= fl_req_in && !fl_ok;
      end
   end

   // reprogramming target follows the location select
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fl_target_loader_out <= 1'b1;
      end else begin
         fl_target_loader_out <= !pbc[PBC_LOC_SEL_BIT];
      end
   end

   // security word: programming only clears bits, erase-all restores them
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sec_word <= SEC_ERASED;
      end else if (pg_erase_all_in && !isp_on) begin
         sec_word <= SEC_ERASED;
      end else if (pg_sec_wr_in && !isp_on && !locked) begin
         sec_word <= sec_word & pg_sec_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pg_refused_out <= 1'b0;
      end else begin
         pg_refused_out <= ((pg_sec_wr_in || pg_erase_all_in) && isp_on) ||
                           (pg_sec_wr_in && !pg_erase_all_in && locked);
      end
   end

   // code-space read routing
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cr_internal_out <= 1'b0;
         cr_external_out <= 1'b0;
      end else if (!cr_req_in) begin
         cr_internal_out <= 1'b0;
         cr_external_out <= 1'b0;
      end else if (cr_from_internal_in) begin
         cr_internal_out <= cr_to_internal_in;
         cr_external_out <= !cr_to_internal_in;
      end else if (!sec_word[SEC_READ_INHIBIT_BIT]) begin
         cr_internal_out <= 1'b0;
         cr_external_out <= 1'b1;
      end else begin
         cr_internal_out <= cr_to_internal_in;
         cr_external_out <= !cr_to_internal_in;
      end
   end

   // port 0 encoding
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         p0_data_out <= BYTE_ZERO;
      end else if (!sec_word[SEC_ENCRYPT_BIT]) begin
         p0_data_out <= p0_data_in ^ P0_KEY;
      end else begin
         p0_data_out <= p0_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         encrypt_active_out <= 1'b0;
      end else begin
         encrypt_active_out <= !sec_word[SEC_ENCRYPT_BIT];
      end
   end

   // oscillator gain control, a programmed zero halves the amplifier
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_half_gain_out <= 1'b0;
      end else begin
         osc_half_gain_out <= !sec_word[SEC_OSC_GAIN_BIT];
      end
   end

   // auxiliary RAM switch follows its control bit
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aux_ram_enable_out <= 1'b0;
      end else begin
         aux_ram_enable_out <= pbc[PBC_AUX_RAM_BIT];
      end
   end

   // programming mode flag for the rest of the chip
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         isp_active_out <= 1'b0;
      end else begin
         isp_active_out <= isp_on;
      end
   end

   // execution source: loader flash in loader boot or while the loader bank runs
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fetch_loader_out <= 1'b0;
      end else begin
         fetch_loader_out <= loader_boot_mode ||
                             (isp_on && pbc[PBC_LOC_SEL_BIT]);
      end
   end

   // register read data, valid only in the cycle after the read strobe
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= BYTE_ZERO;
      end else if (!reg_rd_in) begin
         reg_rdata_out <= BYTE_ZERO;
      end else if (reg_addr_in == PBC_ADDR) begin
         reg_rdata_out <= pbc;
         reg_rdata_out[PBC_SOFT_RESET_BIT] <= loader_boot_mode;
      end else if (reg_addr_in == SEC_VIEW_ADDR) begin
         reg_rdata_out <= (isp_on || locked) ? BYTE_ZERO : sec_word;
      end else if (reg_addr_in == STATUS_ADDR) begin
         reg_rdata_out <= BYTE_ZERO;
         reg_rdata_out[STAT_ISP_ACTIVE_BIT] <= isp_on;
         reg_rdata_out[STAT_LOADER_BOOT_BIT] <= loader_boot_mode;
         reg_rdata_out[STAT_WRITE_OPEN_BIT] <= write_open;
         reg_rdata_out[STAT_FETCH_LOADER_BIT] <= fetch_loader_out;
      end else begin
         reg_rdata_out <= BYTE_ZERO;
      end
   end

endmodule // isp_boot_security_control

// file: isp_boot_pkg.sv
// shared constants and types for the flash programming, boot and security block
package isp_boot_pkg;

   // register addresses on the register port
   localparam logic [7:0] PBC_ADDR = 8'hBF;
   localparam logic [7:0] UNLOCK_ADDR = 8'hF6;
   localparam logic [7:0] SEC_VIEW_ADDR = 8'hF7;
   localparam logic [7:0] STATUS_ADDR = 8'hF8;

   // program_boot_control fields
   localparam int PBC_SOFT_RESET_BIT = 7;
   localparam int PBC_AUX_RAM_BIT = 4;
   localparam int PBC_LOC_SEL_BIT = 1;
   localparam int PBC_PROG_EN_BIT = 0;
   localparam logic [7:0] PBC_RESET = 8'h00;
   localparam logic [7:0] PBC_WRITABLE = 8'h13;

   // status register fields
   localparam int STAT_ISP_ACTIVE_BIT = 0;
   localparam int STAT_LOADER_BOOT_BIT = 1;
   localparam int STAT_WRITE_OPEN_BIT = 2;
   localparam int STAT_FETCH_LOADER_BIT = 3;

   // write-unlock key sequence
   localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h87;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h59;

   // security settings word
   localparam logic [15:0] SEC_WORD_ADDR = 16'hFFFF;
   localparam int SEC_LOCK_BIT = 0;
   localparam int SEC_READ_INHIBIT_BIT = 1;
   localparam int SEC_ENCRYPT_BIT = 2;
   localparam int SEC_OSC_GAIN_BIT = 7;
   localparam logic [7:0] SEC_ERASED = 8'hFF;

   // flash operation codes on the programming port
   localparam logic [1:0] FL_CMD_READ = 2'h0;
   localparam logic [1:0] FL_CMD_PROGRAM = 2'h1;
   localparam logic [1:0] FL_CMD_ERASE = 2'h2;

   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {
      UNLOCK_CLOSED,
      UNLOCK_GOT_FIRST,
      UNLOCK_OPEN
   } unlock_state_type;

   typedef enum logic [1:0] {
      ISP_OFF,
      ISP_ARMED,
      ISP_ON
   } isp_state_type;

endpackage

// file: write_unlock_seq.sv
// two-key write unlock sequencer for the programming control register
`timescale 1ns/1ps
module write_unlock_seq
   import isp_boot_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic clear_in,
   input wire logic key_wr_in,
   input wire logic [7:0] key_in,
   output logic open_out
);
   unlock_state_type state;

   // any key write that does not continue the key sequence closes write access
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= UNLOCK_CLOSED;
      end else if (clear_in) begin
         state <= UNLOCK_CLOSED;
      end else if (key_wr_in) begin
         case (state)
            UNLOCK_CLOSED: begin
               state <= (key_in == UNLOCK_KEY_FIRST) ? UNLOCK_GOT_FIRST : UNLOCK_CLOSED;
            end
            UNLOCK_GOT_FIRST: begin
               if (key_in == UNLOCK_KEY_SECOND) begin
                  state <= UNLOCK_OPEN;
               end else if (key_in == UNLOCK_KEY_FIRST) begin
                  state <= UNLOCK_GOT_FIRST;
               end else begin
                  state <= UNLOCK_CLOSED;
               end
            end
            default: begin
               state <= (key_in == UNLOCK_KEY_FIRST) ? UNLOCK_GOT_FIRST : UNLOCK_CLOSED;
            end
         endcase
      end
   end

   assign open_out = (state == UNLOCK_OPEN);
endmodule // write_unlock_seq

// file: isp_boot_chk.sv
// assertion checker for the programming, boot and security control block
`timescale 1ns/1ps
module isp_boot_chk
   import isp_boot_pkg::*;
#(
   parameter logic [7:0] P0_KEY = 8'h5A
)
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic cpu_idle_in,
   input wire logic wake_irq_in,
   input wire logic fl_req_in,
   input wire logic [1:0] fl_cmd_in,
   input wire logic fl_grant_out,
   input wire logic fl_refused_out,
   input wire logic cr_req_in,
   input wire logic cr_from_internal_in,
   input wire logic cr_to_internal_in,
   input wire logic cr_internal_out,
   input wire logic cr_external_out,
   input wire logic [7:0] p0_data_in,
   input wire logic [7:0] p0_data_out,
   input wire logic soft_reset_out,
   input wire logic isp_active_out,
   input wire logic encrypt_active_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   a_soft_reset_cause: assert property (soft_reset_out |-> $past(reg_wr_in) &&
      $past(reg_addr_in) == PBC_ADDR && ($past(reg_wdata_in) & 8'h83) == 8'h83)
      else $error("soft reset without its write");
   a_soft_reset_pulse: assert property (soft_reset_out |=> !soft_reset_out)
      else $error("soft reset longer than one cycle");
   a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == BYTE_ZERO)
      else $error("read data without a read");
   a_flash_answer: assert property (fl_req_in |=> fl_grant_out != fl_refused_out)
      else $error("flash request not answered once");
   a_flash_cause: assert property (fl_grant_out || fl_refused_out |-> $past(fl_req_in))
      else $error("flash answer without request");
   a_grant_idle: assert property (fl_grant_out |-> $past(cpu_idle_in) &&
      $past(fl_cmd_in) != 2'h3) else $error("flash grant while awake or bad command");
   a_isp_after_wake: assert property ($rose(isp_active_out) |->
      $past(wake_irq_in, 2) || $past(wake_irq_in, 3)) else $error("programming mode without wake");
   a_code_internal: assert property (cr_req_in && cr_from_internal_in |=>
      cr_internal_out == cr_to_internal_in && cr_external_out == !cr_to_internal_in)
      else $error("internal code read misrouted");
   a_code_external: assert property (cr_req_in && !cr_to_internal_in |=>
      cr_external_out && !cr_internal_out) else $error("external code read misrouted");
   a_port0_path: assert property ($past(arst_n_in) && $stable(encrypt_active_out) |->
      p0_data_out == ($past(p0_data_in) ^ (encrypt_active_out ? P0_KEY : BYTE_ZERO)))
      else $error("port 0 data wrongly encoded");
endmodule // isp_boot_chk

bind isp_boot_security_control isp_boot_chk #(.P0_KEY(P0_KEY)) chk_i (.*);

// file: test_isp_boot_security_control.sv
// self-checking testbench for the programming, boot and security control block
`timescale 1ns/1ps
module test_isp_boot_security_control;
   import isp_boot_pkg::*;
   localparam logic [7:0] KEY = 8'h5A;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, p0_data_in = 8'h00;
   logic [7:0] pg_sec_data_in = 8'hFF, reg_rdata_out, p0_data_out, v;
   logic reg_wr_in = 0, reg_rd_in = 0, cpu_idle_in = 0, wake_irq_in = 0, fl_req_in = 0;
   logic strap_p27_in = 1, strap_p26_in = 1, strap_p43_in = 1, cr_req_in = 0;
   logic pg_sec_wr_in = 0, pg_erase_all_in = 0, cr_from_internal_in = 0, cr_to_internal_in = 0;
   logic [1:0] fl_cmd_in = 2'h0;
   logic [15:0] fl_addr_in = 16'h0010;
   logic fl_grant_out, fl_refused_out, fl_target_loader_out, pg_refused_out;
   logic cr_internal_out, cr_external_out, soft_reset_out, aux_ram_enable_out;
   logic isp_active_out, fetch_loader_out, osc_half_gain_out, encrypt_active_out;
   int mismatches = 0, n_tests = 0, cycles = 0;

   isp_boot_security_control #(.P0_KEY(KEY)) DUT (.*);

   always #2.5 clk_in = ~clk_in;

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         tally_and_finish;
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task rd(input logic [7:0] a);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask

   task unlock;
      wr(UNLOCK_ADDR, UNLOCK_KEY_FIRST);
      wr(UNLOCK_ADDR, UNLOCK_KEY_SECOND);
   endtask

   task fop(input logic [1:0] c, input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      fl_cmd_in <= c;
      fl_addr_in <= a;
      fl_req_in <= 1'b1;
      @(posedge clk_in);
      fl_req_in <= 1'b0;
      #1 chk({6'h0, fl_grant_out, fl_refused_out}, exp);
   endtask

   task crd(input logic f, input logic t, input logic [7:0] exp);
      @(posedge clk_in);
      cr_from_internal_in <= f;
      cr_to_internal_in <= t;
      cr_req_in <= 1'b1;
      @(posedge clk_in);
      cr_req_in <= 1'b0;
      #1 chk({6'h0, cr_internal_out, cr_external_out}, exp);
   endtask

   task pg(input logic w, input logic e, input logic [7:0] d);
      @(posedge clk_in);
      pg_sec_wr_in <= w;
      pg_erase_all_in <= e;
      pg_sec_data_in <= d;
      @(posedge clk_in);
      pg_sec_wr_in <= 1'b0;
      pg_erase_all_in <= 1'b0;
      #1 v = {7'h0, pg_refused_out};
      @(posedge clk_in);
      #1;
   endtask

   // straps stay put across the whole reset
   task do_reset;
      @(posedge clk_in);
      arst_n_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask

   task t_regs;
      rd(PBC_ADDR); chk(v, PBC_RESET);
      chk({7'h0, fl_target_loader_out}, 8'h01);
      wr(PBC_ADDR, 8'h10); rd(PBC_ADDR); chk(v, 8'h00);
      unlock;
      wr(PBC_ADDR, 8'h12); rd(PBC_ADDR); chk(v, 8'h12);
      chk({6'h0, aux_ram_enable_out, fl_target_loader_out}, 8'h02);
      wr(UNLOCK_ADDR, 8'h00); wr(PBC_ADDR, 8'h00); rd(PBC_ADDR); chk(v, 8'h12);
      rd(8'h00); chk(v, 8'h00);
      unlock;
   endtask

   task t_isp;
      wr(PBC_ADDR, 8'h01);
      fop(FL_CMD_PROGRAM, 16'h0010, 8'h01);
      @(posedge clk_in) cpu_idle_in <= 1'b1;
      @(posedge clk_in) wake_irq_in <= 1'b1;
      @(posedge clk_in) wake_irq_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      #1 chk({7'h0, isp_active_out}, 8'h01);
      fop(FL_CMD_PROGRAM, 16'h0010, 8'h02);
      fop(FL_CMD_ERASE, 16'h0010, 8'h02);
      fop(FL_CMD_READ, 16'h0010, 8'h02);
      fop(2'h3, 16'h0010, 8'h01);
      fop(FL_CMD_READ, SEC_WORD_ADDR, 8'h01);
      pg(1'b1, 1'b0, 8'h00); chk(v, 8'h01);
      rd(SEC_VIEW_ADDR); chk(v, 8'h00);
      wr(PBC_ADDR, 8'h03); rd(STATUS_ADDR); chk(v, 8'h0D);
      chk({7'h0, fetch_loader_out}, 8'h01);
      fop(FL_CMD_READ, SEC_WORD_ADDR, 8'h02);
      wr(PBC_ADDR, 8'h00);
      fop(FL_CMD_PROGRAM, 16'h0010, 8'h01);
      repeat (2) @(posedge clk_in);
      #1 chk({7'h0, isp_active_out}, 8'h00);
      @(posedge clk_in) cpu_idle_in <= 1'b0;
   endtask

   task t_sec;
      crd(1'b0, 1'b1, 8'h02);
      pg(1'b1, 1'b0, 8'h79); chk(v, 8'h00);
      rd(SEC_VIEW_ADDR); chk(v, 8'h79);
      chk({6'h0, osc_half_gain_out, encrypt_active_out}, 8'h03);
      @(posedge clk_in) p0_data_in <= 8'hA5;
      repeat (3) @(posedge clk_in);
      #1 chk(p0_data_out, 8'hA5 ^ KEY);
      crd(1'b0, 1'b1, 8'h01);
      crd(1'b1, 1'b1, 8'h02);
      crd(1'b1, 1'b0, 8'h01);
      pg(1'b1, 1'b0, 8'hFF); chk({7'h0, osc_half_gain_out}, 8'h01);
      pg(1'b1, 1'b0, 8'hFE);
      rd(SEC_VIEW_ADDR); chk(v, 8'h00);
      pg(1'b1, 1'b0, 8'hFF); chk(v, 8'h01);
      pg(1'b0, 1'b1, 8'h00); chk(v, 8'h00);
      chk({6'h0, osc_half_gain_out, encrypt_active_out}, 8'h00);
      chk(p0_data_out, 8'hA5);
   endtask

   task t_boot;
      logic e;
      for (int i = 0; i < 8; i++) begin
         e = !i[2] || i[1:0] == 2'b00;
         @(posedge clk_in) {strap_p43_in, strap_p27_in, strap_p26_in} <= i[2:0];
         do_reset;
         #1 chk({7'h0, fetch_loader_out}, {7'h0, e});
         rd(PBC_ADDR); chk({7'h0, v[7]}, {7'h0, e});
      end
   endtask

   task t_soft;
      unlock;
      wr(PBC_ADDR, 8'h82);
      #1 chk({7'h0, soft_reset_out}, 8'h00);
      wr(PBC_ADDR, 8'h83);
      #1 chk({7'h0, soft_reset_out}, 8'h01);
      repeat (3) @(posedge clk_in);
      rd(PBC_ADDR); chk(v, 8'h00);
      wr(PBC_ADDR, 8'h10); rd(PBC_ADDR); chk(v, 8'h00);
   endtask

   initial begin
      do_reset;
      t_regs;
      t_isp;
      t_sec;
      t_boot;
      t_soft;
      tally_and_finish;
   end
endmodule // test_isp_boot_security_control
